//--- design/can_xcvr_ctl.sv
// Controller driving a CAN transceiver's transmit and standby pins and reading its receive pin
`timescale 1ns/1ps
`include "can_ctl_defs.svh"
// Operation
// - Drive standby_select low for normal mode
// - Drive standby_select high to request standby
// - Low receive in standby means wake request
// - Only controller leaves standby, by driving low
// - Never hold dominant beyond eleven slowest bits
module can_xcvr_ctl #(
  parameter int BIT_CYC = `BIT_CYC_1M, // Cycles per bit, default 1 Mbit/s
  parameter int DOM_LIMIT = `MAX_DOM_BITS * `BIT_CYC_MAX,
  parameter int WAKE_CYC = `WAKE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_standby_req, // User asks for standby
  input wire logic i_tx_bit, // Bit to send, 0 dominant
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_rxd_pin, // Transceiver receive pin
  output logic o_txd_pin, // Transceiver transmit pin
  output logic o_standby_select, // Transceiver mode pin
  output logic o_rx_bit, // Synchronised receive level
  output logic o_wake, // Wake request seen in standby
  output logic o_dom_err, // Dominant run cut short
  output can_ctl_pkg::mode_t o_mode
);
  import can_ctl_pkg::*;

  localparam int BW = $clog2(DOM_LIMIT + BIT_CYC + 2);
  localparam int WW = $clog2(WAKE_CYC + 2);

  logic [2:0] rx_sync_q; // Three-stage receive synchroniser
  logic rx_lvl_q, rx_lvl_d; // Filtered level, changes when 2 and 3 agree
  mode_t mode_q, mode_d;
  logic [WW-1:0] wcnt_q, wcnt_d; // Wake qualification count
  logic [BW-1:0] bcnt_q, bcnt_d; // Cycles within current bit
  logic [BW-1:0] dom_q, dom_d; // Cycles of current dominant run
  logic txd_q, txd_d;
  logic stb_q, stb_d;
  logic wake_q, wake_d;
  logic err_q, err_d;
  logic buf_valid;
  logic buf_bit;
  logic buf_take;

  // Bit buffer stalls the user when the bit timer is slow
  can_bit_buf #(.WIDTH(1)) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_data(i_tx_bit),
    .i_valid(i_tx_valid),
    .o_ready(o_tx_ready),
    .o_data(buf_bit),
    .o_valid(buf_valid),
    .i_ready(buf_take)
  );

  // Receive pin synchroniser, pin into stage 1, each stage feeds the next
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_sync_q <= 3'h7;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], i_rxd_pin};
    end
  end

  // Bit boundary: take a new bit only in normal mode at bit end
  assign buf_take = (mode_q == ST_NORMAL) && (bcnt_q == BW'(BIT_CYC - 1));

  // Next-state logic
  always_comb
  begin
    rx_lvl_d = rx_lvl_q;
    if (rx_sync_q[1] == rx_sync_q[2])
    begin
      rx_lvl_d = rx_sync_q[2];
    end
    mode_d = mode_q;
    wcnt_d = wcnt_q;
    bcnt_d = bcnt_q;
    dom_d = dom_q;
    txd_d = txd_q;
    stb_d = stb_q;
    wake_d = 1'b0;
    err_d = 1'b0;
    case (mode_q)
      ST_NORMAL:
      begin
        stb_d = `STB_NORMAL;
        // Bit timer runs freely
        if (bcnt_q == BW'(BIT_CYC - 1))
        begin
          bcnt_d = '0;
        end
        else
        begin
          bcnt_d = bcnt_q + 1'b1;
        end
        if (buf_take)
        begin
          // Idle slot sends recessive
          txd_d = buf_valid ? buf_bit : `PIN_RECESSIVE;
        end
        // Count dominant run and force recessive at the limit
        if (txd_q == `PIN_DOMINANT)
        begin
          if (dom_q >= BW'(DOM_LIMIT - 1))
          begin
            txd_d = `PIN_RECESSIVE;
            err_d = 1'b1;
            dom_d = '0;
          end
          else
          begin
            dom_d = dom_q + 1'b1;
          end
        end
        else
        begin
          dom_d = '0;
        end
        if (i_standby_req)
        begin
          mode_d = ST_TO_STBY;
          txd_d = `PIN_RECESSIVE;
        end
      end
      ST_TO_STBY:
      begin
        // Release bus before asking for standby
        stb_d = `STB_STANDBY;
        txd_d = `PIN_RECESSIVE;
        wcnt_d = '0;
        mode_d = ST_STANDBY;
      end
      ST_STANDBY:
      begin
        txd_d = `PIN_RECESSIVE;
        // Qualify a low receive level as wake
        if (rx_lvl_q == `PIN_DOMINANT)
        begin
          if (wcnt_q == WW'(WAKE_CYC))
          begin
            wake_d = 1'b1;
            mode_d = ST_WAKE;
          end
          else
          begin
            wcnt_d = wcnt_q + 1'b1;
          end
        end
        else
        begin
          wcnt_d = '0;
        end
        if (!i_standby_req)
        begin
          // Leaving wins: a wake pulse with the pin low would be stale
          wake_d = 1'b0;
          stb_d = `STB_NORMAL;
          bcnt_d = '0;
          dom_d = '0;
          mode_d = ST_NORMAL;
        end
      end
      ST_WAKE:
      begin
        // Stay in standby until the user leaves it
        txd_d = `PIN_RECESSIVE;
        if (!i_standby_req)
        begin
          stb_d = `STB_NORMAL;
          bcnt_d = '0;
          dom_d = '0;
          mode_d = ST_NORMAL;
        end
      end
      default:
      begin
        mode_d = ST_NORMAL;
        txd_d = `PIN_RECESSIVE;
      end
    endcase
  end

  // State registers, bus released and normal mode after reset
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_lvl_q <= 1'b1;
      mode_q <= ST_NORMAL;
      wcnt_q <= '0;
      bcnt_q <= '0;
      dom_q <= '0;
      txd_q <= 1'b1;
      stb_q <= 1'b0;
      wake_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      rx_lvl_q <= rx_lvl_d;
      mode_q <= mode_d;
      wcnt_q <= wcnt_d;
      bcnt_q <= bcnt_d;
      dom_q <= dom_d;
      txd_q <= txd_d;
      stb_q <= stb_d;
      wake_q <= wake_d;
      err_q <= err_d;
    end
  end

  assign o_txd_pin = txd_q;
  assign o_standby_select = stb_q;
  assign o_rx_bit = rx_lvl_q;
  assign o_wake = wake_q;
  assign o_dom_err = err_q;
  assign o_mode = mode_q;

  // Transmit pin recessive while standby is selected
  stby_recessive_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    stb_q |-> txd_q) else $error("txd dominant in standby");
  // Dominant run never exceeds limit
  dom_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    dom_q < BW'(DOM_LIMIT)) else $error("dominant run too long");
  // Wake only while standby selected
  wake_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    wake_q |-> stb_q) else $error("wake outside standby");
  // Standby request leads to standby pin in two cycles
  sequence s_req_normal;
    i_standby_req && mode_q == ST_NORMAL;
  endsequence
  stby_entry_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s_req_normal |-> ##2 stb_q) else $error("standby late");
  // Leaving standby only on user release
  stby_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (stb_q && i_standby_req) |=> stb_q) else $error("left standby");
  // Release leads to normal pin next cycle
  stby_exit_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (stb_q && !i_standby_req && mode_q != ST_TO_STBY) |=> !stb_q)
    else $error("exit late");
  // Receive level follows agreeing synchroniser stages
  rx_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    (rx_sync_q[1] == rx_sync_q[2]) |=> rx_lvl_q == $past(rx_sync_q[2]))
    else $error("rx level stale");
  // Error pulse comes with recessive pin
  dom_cut_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    err_q |-> txd_q) else $error("cut not recessive");
endmodule : can_xcvr_ctl

//--- design/can_ctl_defs.svh
// Timing constants and pin levels for the transceiver-facing controller
`ifndef CAN_CTL_DEFS_SVH
`define CAN_CTL_DEFS_SVH
// Reference clock period in picoseconds
`define CLK_PERIOD_PS 5000
// Standby wake-up filter time in ns
`define WAKE_FILTER_NS 3000
// Shortest dominant time-out of the transceiver, in us
`define DOM_TIMEOUT_MIN_US 300
// Longest legal dominant run in bits
`define MAX_DOM_BITS 11
// Slowest allowed bit rate in kbit/s
`define MIN_BITRATE_KBPS 40
// Bit time at the slowest rate in ns
`define BIT_NS_MAX (1000000 / `MIN_BITRATE_KBPS)
// Cycles per bit at the slowest rate
`define BIT_CYC_MAX ((`BIT_NS_MAX * 1000) / `CLK_PERIOD_PS)
// Cycles per bit at 1 Mbit/s on the reference clock
`define BIT_CYC_1M 200
// Cycles of the dominant budget, rounded down (longest time)
`define DOM_BUDGET_CYC ((`DOM_TIMEOUT_MIN_US * 1000000) / `CLK_PERIOD_PS)
// Cycles the received low must last in standby to count as wake
// Filter time in ps, rounded up to whole cycles below
`define WAKE_PS (`WAKE_FILTER_NS * 1000)
`define WAKE_CYC ((`WAKE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Pin levels
`define PIN_RECESSIVE 1'b1
`define PIN_DOMINANT 1'b0
`define STB_NORMAL 1'b0
`define STB_STANDBY 1'b1
`endif

//--- design/can_ctl_pkg.sv
// Types shared by the transceiver controller
package can_ctl_pkg;
  // Mode states, Gray coded along normal -> to_standby -> standby -> wake
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_TO_STBY = 2'b01,
    ST_STANDBY = 2'b11,
    ST_WAKE = 2'b10
  } mode_t;
endpackage : can_ctl_pkg

//--- design/can_bit_buf.sv
// Two-entry valid/ready buffer for transmit bits
`timescale 1ns/1ps
module can_bit_buf #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  logic [WIDTH-1:0] mem_q [2]; // Storage slots
  logic [WIDTH-1:0] mem_d [2];
  logic wr_q, wr_d; // Write slot
  logic rd_q, rd_d; // Read slot
  logic [1:0] cnt_q, cnt_d; // Fill level
  logic ready_q, ready_d; // Registered not-full flag
  logic push;
  logic pop;

  // Next-state of the ring
  always_comb
  begin
    push = i_valid && (cnt_q != 2'h2);
    pop = i_ready && (cnt_q != 2'h0);
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push)
    begin
      mem_d[wr_q] = i_data;
      wr_d = ~wr_q;
    end
    if (pop)
    begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    // Ready from the next fill level, so it leaves a flip-flop
    ready_d = (cnt_d != 2'h2);
  end

  // Registers only
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mem_q[0] <= '1;
      mem_q[1] <= '1;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      ready_q <= 1'b1;
    end
    else
    begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  // Honest full and empty
  assign o_ready = ready_q;
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rd_q];
endmodule : can_bit_buf

//--- test/can_xcvr_model.sv
// Behavioural transceiver model facing the controller's pins
`timescale 1ns/1ps
module can_xcvr_model #(
  parameter int TOUT_CYC = 100, // Dominant time-out, shortened
  parameter int WAKE_DLY = 600 // Standby filter, 3 us at 200 MHz
) (
  input wire logic i_ref_clk,
  input wire logic i_txd,
  input wire logic i_stb,
  input wire logic i_bus_dom, // Another node drives dominant
  output logic o_rxd,
  output logic o_timed_out
);
  logic txd_eff;
  logic stb_eff;
  logic bus_dom;
  logic drv_off_q = 1'b0; // Transmitter cut by the timer
  logic txd_prev_q = 1'b1;
  int dom_cnt = 0;
  int act_cnt = 0;
  // Open inputs read high through pull-ups
  assign txd_eff = (i_txd === 1'b0) ? 1'b0 : 1'b1;
  assign stb_eff = (i_stb === 1'b0) ? 1'b0 : 1'b1;
  // Transmitter is off in standby and after a time-out
  assign bus_dom = i_bus_dom |
    (!stb_eff & !txd_eff & !drv_off_q);
  // Standby only shows dominant runs past the filter; mode follows pin
  assign o_rxd = stb_eff ? !(act_cnt > WAKE_DLY)
    : !bus_dom;
  assign o_timed_out = drv_off_q;
  // Dominant timer and activity filter
  always @(posedge i_ref_clk)
  begin
    txd_prev_q <= txd_eff;
    if (txd_prev_q && !txd_eff)
      dom_cnt <= 0;
    else if (!txd_eff)
      dom_cnt <= dom_cnt + 1;
    if (!txd_prev_q && txd_eff)
      drv_off_q <= 1'b0;
    else if (!txd_eff && dom_cnt >= TOUT_CYC)
      drv_off_q <= 1'b1;
    act_cnt <= bus_dom ? act_cnt + 1 : 0;
  end
endmodule : can_xcvr_model

//--- test/tb_top.sv
// Self-checking bench for the transceiver controller
`timescale 1ns/1ps
module tb_top;
  import can_ctl_pkg::*;
  localparam int BC = 4; // Cycles per bit, shortened
  localparam int DL = 50; // Dominant limit, shortened
  logic clk = 0, nrst = 0, req = 0, tbit = 1, tval = 0, bus = 0;
  logic rdy, txd, stb, rxd, rxb, wake, derr, tout;
  logic wake_seen = 0, derr_seen = 0;
  mode_t mode;
  logic exp_q[$]; // Expected transmit bits, oldest first
  int n_errors = 0, num_checks = 0, cyc = 0, run = 0, max_run = 0;
  bit mon_on = 0;
  always #2.5 clk = ~clk;
  can_xcvr_ctl #(.BIT_CYC(BC), .DOM_LIMIT(DL), .WAKE_CYC(10)) u_dut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_standby_req(req), .i_tx_bit(tbit),
    .i_tx_valid(tval), .o_tx_ready(rdy), .i_rxd_pin(rxd), .o_txd_pin(txd),
    .o_standby_select(stb), .o_rx_bit(rxb), .o_wake(wake),
    .o_dom_err(derr), .o_mode(mode));
  can_xcvr_model u_xcvr (.i_ref_clk(clk), .i_txd(txd), .i_stb(stb),
    .i_bus_dom(bus), .o_rxd(rxd), .o_timed_out(tout));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Offer one bit at a falling edge, hold it until the buffer takes it
  task automatic send(input logic b);
    tval = 1;
    tbit = b;
    while (!rdy)
      @(negedge clk);
    @(negedge clk);
  endtask : send
  // Watchdog, pulse catchers and dominant run length
  always @(posedge clk)
  begin
    cyc++;
    wake_seen |= (wake === 1'b1);
    derr_seen |= (derr === 1'b1);
    run = (txd === 1'b0) ? run + 1 : 0;
    if (run > max_run)
      max_run = run;
    if (cyc > 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // Monitor: align on the first dominant slot, then sample mid-slot
  initial forever
  begin
    @(posedge clk iff (mon_on && txd === 1'b0));
    repeat (BC / 2) @(posedge clk);
    while (exp_q.size() > 0)
    begin
      check(txd, exp_q.pop_front());
      repeat (BC) @(posedge clk);
    end
  end
  initial
  begin
    logic b;
    int w;
    void'($urandom(77));
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({txd, stb, rdy}, 8'h05);
    nrst = 1;
    // Random stream, back to back, through the buffer
    mon_on = 1;
    exp_q.push_back(1'b0);
    send(1'b0);
    for (int i = 0; i < 24; i++)
    begin
      b = 1'($urandom_range(1, 0));
      exp_q.push_back(b);
      send(b);
    end
    tval = 0;
    repeat (BC * 4) @(negedge clk);
    check(8'(exp_q.size()), 8'h00);
    mon_on = 0;
    $display("test stream done");
    // Overlong dominant must be cut by the controller
    for (int i = 0; i < 15; i++)
      send(1'b0);
    tval = 0;
    repeat (BC * 4) @(negedge clk);
    check(8'(max_run <= DL && max_run > DL - BC), 8'h01);
    check({derr_seen, tout}, 8'h02);
    $display("test dominant limit done");
    // Standby entry, blocked transmit, wake, exit
    req = 1;
    repeat (2) @(negedge clk);
    check({stb, mode}, {5'h00, 1'b1, ST_STANDBY});
    send(1'b0);
    tval = 0;
    repeat (BC * 3) @(negedge clk);
    check(txd, 1'b1);
    bus = 1;
    w = 0;
    while (!wake_seen && w < 1000)
    begin
      @(negedge clk);
      w++;
    end
    check(8'(w > 600), 8'h01);
    check({wake_seen, stb, mode}, {4'h0, 2'b11, ST_WAKE});
    bus = 0;
    req = 0;
    repeat (2) @(negedge clk);
    check({stb, mode}, {6'h00, ST_NORMAL});
    $display("test standby done");
    // Receive path in normal mode
    bus = 1;
    repeat (6) @(negedge clk);
    check(rxb, 1'b0);
    bus = 0;
    repeat (6) @(negedge clk);
    check(rxb, 1'b1);
    $display("test receive done");
    wrap_up();
  end
endmodule : tb_top
